// ---- hw/pml_defs.svh ----
`ifndef PML_DEFS_SVH
`define PML_DEFS_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define PML_IDX_PORT_MODE      4'h4
`define PML_IDX_LINE_IO        4'h5
`define PML_IDX_PORT_STATUS    4'h6

// ----------------------------------------------------------------
// Port mode control fields
// ----------------------------------------------------------------
`define PML_PM_MASTER_RST_BIT  7
`define PML_PM_STATE_RST_BIT   6
`define PML_PM_SRC_LOOP_BIT    5
`define PML_PM_FE_LOOP_BIT     4
`define PML_PM_MODE_MSB        2
`define PML_PM_MODE_LSB        0
`define PML_PM_RESET           8'h00
`define PML_PM_WR_MASK         8'hf7

// ----------------------------------------------------------------
// Line polarity control fields
// ----------------------------------------------------------------
`define PML_IO_RX_SYNC_HI_BIT  6
`define PML_IO_RX_CLK_FALL_BIT 5
`define PML_IO_TX_SYNC_HI_BIT  4
`define PML_IO_TX_CLK_FALL_BIT 3
`define PML_IO_RESET           8'h00
`define PML_IO_WR_MASK         8'h78

// ----------------------------------------------------------------
// Interface mode codes
// ----------------------------------------------------------------
`define PML_MODE_T1            3'h0
`define PML_MODE_E1            3'h1
`define PML_MODE_GP            3'h5
`define PML_MODE_DSL           3'h6
`define PML_MODE_PWR_DOWN      3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PML_CLK_PERIOD_NS      4
`define PML_MASTER_RST_NS      16

`endif

// ---- hw/pml_pkg.sv ----
package pml_pkg;

    // Port sequencing states, one-hot
    typedef enum logic [3:0] {
        PML_ST_MASTER_RST = 4'h1,
        PML_ST_STATE_RST  = 4'h2,
        PML_ST_RUN        = 4'h4,
        PML_ST_IDLE       = 4'h8
    } pml_port_state_t;

endpackage

// ---- hw/pml_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Two-stage synchroniser for line pins
// ----------------------------------------------------------------
module pml_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;   // First stage, read only by second
    logic [WIDTH-1:0] sync_r;   // Second stage

    // Register both stages
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule

`default_nettype wire

// ---- hw/pml_line_edge.sv ----
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Active-edge finder for a sampled line clock
// ----------------------------------------------------------------
module pml_line_edge (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_level,
    input  wire logic i_falling,
    output logic      o_edge
);

    logic prev_r;   // Level seen one cycle before
    logic armed_r;  // Blocks a false edge right after reset

    // Track last level
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            prev_r  <= 1'b0;
            armed_r <= 1'b0;
        end
        else
        begin
            prev_r  <= i_level;
            armed_r <= 1'b1;
        end
    end

    // Pick falling or rising transition
    assign o_edge = armed_r & (i_falling ? (prev_r & ~i_level) : (~prev_r & i_level));

endmodule

`default_nettype wire

// ---- hw/pml_port_mode_line_config.sv ----
// Notes on behaviour
// - Master reset bit restarts port and registers
// - Master reset bit clears itself when the reset time ends
// - State reset clears machines, keeps registers
// - State reset floats port outputs
// - Source loopback feeds transmit into receive
// - Source loopback forces general purpose mode
// - Far-end loopback returns receive data outward
// - Mode field selects T1/E1/GP/DSL/power-down
// - General purpose mode ignores both sync inputs
// - Receive sync active level select
// - Receive clock sampling edge select
// - Transmit sync active level select
// - Transmit clock active edge select
`include "pml_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module pml_port_mode_line_config (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Line pins
    input  wire logic        i_line_rx_clock_in,
    input  wire logic        i_line_rx_data_in,
    input  wire logic        i_line_rx_sync_in,
    input  wire logic        i_line_tx_clock_in,
    input  wire logic        i_line_tx_sync_in,
    output logic             o_line_tx_data,
    output logic             o_line_tx_data_oe_n,
    // Cell side
    input  wire logic        i_tx_bit,
    output logic             o_tx_bit_take,
    output logic             o_tx_frame,
    output logic             o_rx_bit,
    output logic             o_rx_bit_valid,
    output logic             o_rx_frame,
    output logic             o_port_active
);

    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------
    localparam int MRST_CYCLES_I = (`PML_MASTER_RST_NS + `PML_CLK_PERIOD_NS - 1) / `PML_CLK_PERIOD_NS;
    localparam logic [3:0] MRST_CYCLES = MRST_CYCLES_I[3:0];

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]  port_mode_control_r;          // Port mode control
    logic [7:0]  port_mode_control_nxt;
    logic [7:0]  lio_r;            // Line polarity control
    logic [7:0]  lio_nxt;
    logic [3:0]  mrst_cnt_r;       // Master reset length counter
    logic [3:0]  mrst_cnt_nxt;
    logic [31:0] prdata_r;         // Registered read data
    logic [31:0] prdata_nxt;
    logic        pslverr_r;        // Registered error answer
    logic        pslverr_nxt;
    logic        setup;            // APB setup cycle
    logic        wr_go;            // Write takes effect
    logic [3:0]  idx;              // Register index
    logic        addr_ok;          // Mapped and aligned
    logic [7:0]  status;           // Port status readback
    pml_pkg::pml_port_state_t st_r;
    pml_pkg::pml_port_state_t st_nxt;
    logic [2:0]  eff_mode;         // Effective interface mode
    logic        gp_mode;          // Syncs disregarded
    logic        mode_live;        // Mode moves data
    logic        run;              // Port datapath running
    logic        dp_rst;           // Datapath machines reset
    logic [4:0]  pins_s;           // Synchronised pins
    logic        rx_clk_lvl;       // Receive clock after loop mux
    logic        rx_dat_lvl;       // Receive data after loop mux
    logic        rx_edge;
    logic        tx_edge;
    logic        rx_sync_act;
    logic        tx_sync_act;
    logic        rx_bit_r;
    logic        rx_bit_nxt;
    logic        rx_val_r;
    logic        rx_val_nxt;
    logic        rx_frm_r;
    logic        rx_frm_nxt;
    logic        tx_dat_r;
    logic        tx_dat_nxt;
    logic        tx_take_r;
    logic        tx_take_nxt;
    logic        tx_frm_r;
    logic        tx_frm_nxt;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign setup   = i_psel & ~i_penable;
    assign wr_go   = i_psel & i_penable & i_pwrite;
    assign idx     = i_paddr[5:2];
    assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[7:6] == 2'h0) &&
                     ((idx == `PML_IDX_PORT_MODE) || (idx == `PML_IDX_LINE_IO) || (idx == `PML_IDX_PORT_STATUS));
    assign status  = {st_r, 1'b0, eff_mode};

    // Read data and error are captured in the setup cycle
    always_comb
    begin
        prdata_nxt  = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup)
        begin
            pslverr_nxt = ~addr_ok;
            prdata_nxt  = 32'h0;
            case (idx)
                `PML_IDX_PORT_MODE:   prdata_nxt = {24'h0, port_mode_control_r};
                `PML_IDX_LINE_IO:     prdata_nxt = {24'h0, lio_r};
                `PML_IDX_PORT_STATUS: prdata_nxt = {24'h0, status};
                default:              prdata_nxt = 32'h0;
            endcase
            if (!addr_ok)
                prdata_nxt = 32'h0;
        end
    end

    // Register the bus answer
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign o_prdata  = prdata_r;
    assign o_pslverr = pslverr_r & i_psel & i_penable;
    assign o_pready  = 1'b1;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Writes, master reset restore and self clear
    always_comb
    begin
        port_mode_control_nxt    = port_mode_control_r;
        lio_nxt      = lio_r;
        mrst_cnt_nxt = mrst_cnt_r;
        if (port_mode_control_r[`PML_PM_MASTER_RST_BIT])
        begin
            // Hold defaults while the master reset runs
            port_mode_control_nxt[6:0] = 7'(`PML_PM_RESET);
            lio_nxt        = `PML_IO_RESET;
            if (mrst_cnt_r == 4'h0)
                port_mode_control_nxt[`PML_PM_MASTER_RST_BIT] = 1'b0;
            else
                mrst_cnt_nxt = mrst_cnt_r - 4'h1;
        end
        else if (wr_go && addr_ok && (idx == `PML_IDX_PORT_MODE))
        begin
            // Reserved bit 3 is not stored
            port_mode_control_nxt = i_pwdata[7:0] & `PML_PM_WR_MASK;
            if (i_pwdata[`PML_PM_MASTER_RST_BIT])
            begin
                port_mode_control_nxt[6:0] = 7'(`PML_PM_RESET);
                lio_nxt        = `PML_IO_RESET;
                mrst_cnt_nxt   = MRST_CYCLES - 4'h1;
            end
        end
        else if (wr_go && addr_ok && (idx == `PML_IDX_LINE_IO))
        begin
            // Only polarity bits are stored
            lio_nxt = i_pwdata[7:0] & `PML_IO_WR_MASK;
        end
    end

    // Register control state
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            port_mode_control_r    <= `PML_PM_RESET;
            lio_r      <= `PML_IO_RESET;
            mrst_cnt_r <= 4'h0;
        end
        else
        begin
            port_mode_control_r    <= port_mode_control_nxt;
            lio_r      <= lio_nxt;
            mrst_cnt_r <= mrst_cnt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Mode selection
    // ----------------------------------------------------------------
    // Source loopback overrides the mode field
    always_comb
    begin
        eff_mode = port_mode_control_r[`PML_PM_MODE_MSB:`PML_PM_MODE_LSB];
        if (port_mode_control_r[`PML_PM_SRC_LOOP_BIT])
            eff_mode = `PML_MODE_GP;
        case (eff_mode)
            `PML_MODE_T1,
            `PML_MODE_E1,
            `PML_MODE_DSL: mode_live = 1'b1;
            `PML_MODE_GP:  mode_live = 1'b1;
            default:       mode_live = 1'b0;
        endcase
    end

    assign gp_mode = (eff_mode == `PML_MODE_GP);

    // ----------------------------------------------------------------
    // Port sequencer
    // ----------------------------------------------------------------
    // Master reset, state reset, running or idle
    always_comb
    begin
        case (st_r)
            pml_pkg::PML_ST_MASTER_RST,
            pml_pkg::PML_ST_STATE_RST,
            pml_pkg::PML_ST_RUN,
            pml_pkg::PML_ST_IDLE:
            begin
                if (port_mode_control_r[`PML_PM_MASTER_RST_BIT])
                    st_nxt = pml_pkg::PML_ST_MASTER_RST;
                else if (port_mode_control_r[`PML_PM_STATE_RST_BIT])
                    st_nxt = pml_pkg::PML_ST_STATE_RST;
                else if (mode_live)
                    st_nxt = pml_pkg::PML_ST_RUN;
                else
                    st_nxt = pml_pkg::PML_ST_IDLE;
            end
            default: st_nxt = pml_pkg::PML_ST_MASTER_RST;
        endcase
    end

    // Register sequencer state
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            st_r <= pml_pkg::PML_ST_MASTER_RST;
        else
            st_r <= st_nxt;
    end

    assign run    = (st_r == pml_pkg::PML_ST_RUN);
    assign dp_rst = i_rst | (st_r == pml_pkg::PML_ST_MASTER_RST) | (st_r == pml_pkg::PML_ST_STATE_RST);

    // ----------------------------------------------------------------
    // Line pins
    // ----------------------------------------------------------------
    pml_sync #(
        .WIDTH (5)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async ({i_line_tx_sync_in, i_line_tx_clock_in, i_line_rx_sync_in,
                   i_line_rx_data_in, i_line_rx_clock_in}),
        .o_sync  (pins_s)
    );

    // Source loopback takes transmit clock and data as receive
    assign rx_clk_lvl = port_mode_control_r[`PML_PM_SRC_LOOP_BIT] ? pins_s[3] : pins_s[0];
    assign rx_dat_lvl = port_mode_control_r[`PML_PM_SRC_LOOP_BIT] ? tx_dat_r  : pins_s[1];

    pml_line_edge u_rx_edge (
        .i_clk     (i_clk),
        .i_rst     (dp_rst),
        .i_level   (rx_clk_lvl),
        .i_falling (lio_r[`PML_IO_RX_CLK_FALL_BIT]),
        .o_edge    (rx_edge)
    );

    pml_line_edge u_tx_edge (
        .i_clk     (i_clk),
        .i_rst     (dp_rst),
        .i_level   (pins_s[3]),
        .i_falling (lio_r[`PML_IO_TX_CLK_FALL_BIT]),
        .o_edge    (tx_edge)
    );

    // Sync qualified by polarity, ignored in general purpose mode
    assign rx_sync_act = ~gp_mode & (pins_s[2] == lio_r[`PML_IO_RX_SYNC_HI_BIT]);
    assign tx_sync_act = ~gp_mode & (pins_s[4] == lio_r[`PML_IO_TX_SYNC_HI_BIT]);

    // ----------------------------------------------------------------
    // Line datapath
    // ----------------------------------------------------------------
    // Sample receive bits, launch transmit bits
    always_comb
    begin
        rx_bit_nxt  = rx_bit_r;
        rx_val_nxt  = 1'b0;
        rx_frm_nxt  = 1'b0;
        tx_dat_nxt  = tx_dat_r;
        tx_take_nxt = 1'b0;
        tx_frm_nxt  = 1'b0;
        if (run && rx_edge)
        begin
            rx_bit_nxt = rx_dat_lvl;
            rx_val_nxt = 1'b1;
            rx_frm_nxt = rx_sync_act;
        end
        if (run && tx_edge)
        begin
            // Far-end loopback sends received data back out
            tx_dat_nxt  = port_mode_control_r[`PML_PM_FE_LOOP_BIT] ? rx_bit_r : i_tx_bit;
            tx_take_nxt = ~port_mode_control_r[`PML_PM_FE_LOOP_BIT];
            tx_frm_nxt  = tx_sync_act;
        end
    end

    // Register datapath, cleared by either port reset
    always_ff @(posedge i_clk)
    begin
        if (dp_rst)
        begin
            rx_bit_r  <= 1'b0;
            rx_val_r  <= 1'b0;
            rx_frm_r  <= 1'b0;
            tx_dat_r  <= 1'b0;
            tx_take_r <= 1'b0;
            tx_frm_r  <= 1'b0;
        end
        else
        begin
            rx_bit_r  <= rx_bit_nxt;
            rx_val_r  <= rx_val_nxt;
            rx_frm_r  <= rx_frm_nxt;
            tx_dat_r  <= tx_dat_nxt;
            tx_take_r <= tx_take_nxt;
            tx_frm_r  <= tx_frm_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_line_tx_data      = tx_dat_r;
    assign o_line_tx_data_oe_n = ~run;
    assign o_tx_bit_take       = tx_take_r;
    assign o_tx_frame          = tx_frm_r;
    assign o_rx_bit            = rx_bit_r;
    assign o_rx_bit_valid      = rx_val_r;
    assign o_rx_frame          = rx_frm_r;
    assign o_port_active       = run;

endmodule

`default_nettype wire

// ---- dv/pml_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Port checker, bound to the port configuration block
// ----------------------------------------------------------------
module pml_monitor (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_psel,
    input wire logic       i_penable,
    input wire logic       i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic       o_pslverr,
    input wire logic       o_line_tx_data_oe_n,
    input wire logic       o_tx_bit_take,
    input wire logic       o_tx_frame,
    input wire logic       o_rx_bit_valid,
    input wire logic       o_rx_frame,
    input wire logic       o_port_active
);
    // One clock domain, one reset
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // Completing access phase
    sequence acc_s;
        i_psel && i_penable;
    endsequence
    // Write that starts a port master reset
    sequence mrst_wr_s;
        acc_s ##0 (i_pwrite && i_paddr == 8'h10 && i_pwdata[7]);
    endsequence
    // Port has been out of run for two samples
    sequence parked_s;
        !o_port_active && $past(!o_port_active);
    endsequence

    mrst_stop_a: assert property (mrst_wr_s |-> ##[1:2] !o_port_active)
        else $error("port stayed active after master reset");
    mrst_float_a: assert property (mrst_wr_s |-> ##2 o_line_tx_data_oe_n [*2])
        else $error("line driven during master reset");
    park_float_a: assert property (parked_s |-> o_line_tx_data_oe_n)
        else $error("line driven outside run");
    park_quiet_a: assert property (parked_s |-> !o_rx_bit_valid && !o_tx_bit_take)
        else $error("line activity outside run");
    rx_pulse_a: assert property (o_rx_bit_valid |=> !o_rx_bit_valid)
        else $error("receive valid longer than one cycle");
    take_pulse_a: assert property (o_tx_bit_take |=> !o_tx_bit_take)
        else $error("transmit take longer than one cycle");
    rx_frame_a: assert property (o_rx_frame |-> o_rx_bit_valid)
        else $error("receive frame without a bit");
    tx_frame_a: assert property (o_tx_frame |=> !o_tx_frame)
        else $error("transmit frame longer than one cycle");
    bad_addr_a: assert property (acc_s ##0 (i_paddr[1:0] != 2'h0) |-> o_pslverr)
        else $error("misaligned access not refused");
endmodule

bind pml_port_mode_line_config pml_monitor u_mon (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pslverr(o_pslverr),
    .o_line_tx_data_oe_n(o_line_tx_data_oe_n), .o_tx_bit_take(o_tx_bit_take), .o_tx_frame(o_tx_frame),
    .o_rx_bit_valid(o_rx_bit_valid), .o_rx_frame(o_rx_frame), .o_port_active(o_port_active)
);

`default_nettype wire

// ---- dv/pml_line_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Line device model: one 8-bit frame per request, 32 ns bit time
// ----------------------------------------------------------------
module pml_line_model (
    input  wire logic       i_go,
    input  wire logic [7:0] i_bits,
    input  wire logic       i_rx_fall,
    input  wire logic       i_tx_fall,
    input  wire logic       i_rx_hi,
    input  wire logic       i_tx_hi,
    output logic            o_busy,
    output logic            o_rx_clk,
    output logic            o_tx_clk,
    output logic            o_rx_data,
    output logic            o_rx_sync,
    output logic            o_tx_sync
);
    logic       busy_r = 1'b0;  // Frame in progress
    logic       ph     = 1'b1;  // High after an active edge, also at idle
    logic       sync_on = 1'b0; // Frame marker on the first bit
    logic       junk   = 1'b0;  // Idle data, never a stale bit
    logic [7:0] sr;             // Bits still to send, first bit on top
    int         i;

    // Clocks stand still between frames; data changes 6 ns after the inactive edge
    assign o_busy    = busy_r;
    assign o_rx_clk  = ph ^ i_rx_fall;
    assign o_tx_clk  = ph ^ i_tx_fall;
    assign o_rx_data = busy_r ? sr[7] : junk;
    assign o_rx_sync = sync_on ~^ i_rx_hi;
    assign o_tx_sync = sync_on ~^ i_tx_hi;

    // Undriven data wanders while idle
    always
    begin
        #4.1;
        junk = ~junk;
    end

    // Frame generator, starts 1.3 ns after the block clock edge that raises i_go
    always
    begin
        wait (i_go === 1'b1);
        #1.3;
        sr = i_bits;
        busy_r = 1'b1;
        for (i = 0; i < 8; i++)
        begin
            ph = 1'b0;
            #6;
            sync_on = (i == 0);
            if (i > 0)
                sr = sr << 1;
            #10;
            ph = 1'b1;
            #16;
        end
        sync_on = 1'b0;
        busy_r = 1'b0;
        wait (i_go === 1'b0);
    end
endmodule

`default_nettype wire

// ---- dv/test_pml_port_mode_line_config.sv ----
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Self-checking bench for the port configuration block
// ----------------------------------------------------------------
module test_pml_port_mode_line_config;
    localparam logic [7:0] A_PM = 8'h10; // Port mode control
    localparam logic [7:0] A_IO = 8'h14; // Line polarity control
    localparam logic [7:0] A_ST = 8'h18; // Status
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, bits = 8'h00, cur_pm = 8'h00, io_cur = 8'h00, rx_sr = 8'h00, tx_sr, tx_ex, e;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'hfa03acb8, tx_s = 32'hfa03acb8;
    logic        pready, pslverr, tx_data, oe_n, take, txf, rxb, rxv, rxf, act, busy;
    logic        go = 1'b0, tx_bit = 1'b0, tx_d = 1'b0;
    wire logic   lrx_clk, ltx_clk, lrx_dat, lrx_syn, ltx_syn;
    int          n_errors = 0, checked = 0, n_valid, n_rxf, n_take, n_txf, k;

    pml_port_mode_line_config dut (
        .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_line_rx_clock_in(lrx_clk), .i_line_rx_data_in(lrx_dat), .i_line_rx_sync_in(lrx_syn),
        .i_line_tx_clock_in(ltx_clk), .i_line_tx_sync_in(ltx_syn), .o_line_tx_data(tx_data),
        .o_line_tx_data_oe_n(oe_n), .i_tx_bit(tx_bit), .o_tx_bit_take(take), .o_tx_frame(txf),
        .o_rx_bit(rxb), .o_rx_bit_valid(rxv), .o_rx_frame(rxf), .o_port_active(act));
    pml_line_model u_line (
        .i_go(go), .i_bits(bits), .i_rx_fall(io_cur[5]), .i_tx_fall(io_cur[3]), .i_rx_hi(io_cur[6]),
        .i_tx_hi(io_cur[4]), .o_busy(busy), .o_rx_clk(lrx_clk), .o_tx_clk(ltx_clk), .o_rx_data(lrx_dat),
        .o_rx_sync(lrx_syn), .o_tx_sync(ltx_syn));

    // Clock and random transmit bits
    always #2 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Expected status: run for T1, E1, general purpose, DSL
    function automatic logic [7:0] st_exp(input logic [2:0] m);
        return {(m inside {3'h0, 3'h1, 3'h5, 3'h6}) ? 4'h4 : 4'h8, 1'b0, m};
    endfunction

    // Event counters on the cell side
    always @(posedge clk)
    begin
        tx_s <= xs(tx_s);
        tx_bit <= tx_s[0];
        tx_d <= tx_bit;
        if (rxv === 1'b1)
        begin
            n_valid++;
            rx_sr <= {rx_sr[6:0], rxb};
        end
        if (rxf === 1'b1) n_rxf++;
        if (take === 1'b1)
        begin
            n_take++;
            tx_sr <= {tx_sr[6:0], tx_data};
            tx_ex <= {tx_ex[6:0], tx_d};
        end
        if (txf === 1'b1) n_txf++;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One bus transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        er;
        apb(1'b1, a, d, r, er);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input logic experr);
        logic [31:0] r;
        logic        er;
        apb(1'b0, a, 8'h00, r, er);
        check("read data", r, {24'h0, exp});
        check("slave error", {31'h0, er}, {31'h0, experr});
    endtask
    // Setup changes only under a port state reset
    task automatic cfg(input logic [7:0] pm, input logic [7:0] io);
        wr(A_PM, 8'h40 | cur_pm);
        wr(A_IO, io);
        io_cur = io;
        wr(A_PM, 8'h40 | pm);
        wr(A_PM, pm);
        cur_pm = pm;
    endtask
    // One random frame from the line device, then count what came out
    task automatic frame(input int ev, input int erf, input int et, input int etf, input logic eoe);
        int n;
        seed = xs(seed);
        @(negedge clk);
        n_valid = 0;
        n_rxf = 0;
        n_take = 0;
        n_txf = 0;
        @(posedge clk);
        bits <= seed[7:0];
        go <= 1'b1;
        repeat (2) @(posedge clk);
        go <= 1'b0;
        for (n = 0; n < 200 && busy === 1'b1; n++) @(posedge clk);
        if (n == 200) n_errors++;
        repeat (12) @(posedge clk);
        check("rx bits", n_valid, ev);
        check("rx frames", n_rxf, erf);
        check("tx takes", n_take, et);
        if (etf >= 0) check("tx frames", n_txf, etf);
        if (ev == 8 && !cur_pm[5]) check("rx data", rx_sr, bits);
        if (cur_pm[5]) check("loop data", rx_sr, {1'b0, tx_ex[7:1]});
        if (et == 8) check("tx data", tx_sr, tx_ex);
        check("float", oe_n, eoe);
    endtask

    task wrap_up;
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (40000) @(posedge clk);
        n_errors++;
        wrap_up;
    end

    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdchk(A_PM, 8'h00, 1'b0);
        rdchk(A_IO, 8'h00, 1'b0);
        rdchk(8'h1c, 8'h00, 1'b1);
        rdchk(8'h11, 8'h00, 1'b1);
        for (k = 0; k < 8; k++)
        begin
            cfg(k[7:0], 8'h50);
            e = st_exp(k[2:0]);
            rdchk(A_ST, e, 1'b0);
            check("active", act, e[6]);
        end
        for (k = 0; k < 4; k++)
        begin
            e = {1'b0, k[1], k[0], k[0], k[1], 3'b000};
            cfg(8'h00, e);
            rdchk(A_IO, e, 1'b0);
            frame(8, 1, 8, 1, 1'b0);
        end
        cfg(8'h05, 8'h00);
        frame(8, 0, 8, 0, 1'b0);
        cfg(8'h22, 8'h00);
        rdchk(A_ST, 8'h45, 1'b0);
        frame(8, 0, 8, 0, 1'b0);
        cfg(8'h10, 8'h00);
        frame(8, 1, 0, -1, 1'b0);
        wr(A_PM, 8'h40);
        frame(0, 0, 0, 0, 1'b1);
        rdchk(A_PM, 8'h40, 1'b0);
        cfg(8'h25, 8'h78);
        wr(A_PM, 8'h80);
        rdchk(A_PM, 8'h80, 1'b0);
        repeat (8) @(posedge clk);
        rdchk(A_PM, 8'h00, 1'b0);
        rdchk(A_IO, 8'h00, 1'b0);
        wrap_up;
    end
endmodule

`default_nettype wire
